// ===== hw/qbt_top.v
// quad bus transceiver with wishbone control and open-drain bus
// Behaviour
// - four-bit register fed by A/B multiplexers
// - select low loads A, high loads B
// - load only on driver clock rising edge
// - drive enable high releases all bus lines
// - bus line carries inverted register bit
// - receiver outputs invert sensed bus level
// - driven and received bit keeps polarity
// - receiver senses resolved bus it drives
// - hold low: latch follows inverted bus
// - hold high: latch keeps captured value
// - one shared enable for receiver outputs
// - output disable leaves latch unchanged
// - driver only pulls low or releases
`timescale 1ns/1ps
`include "qbt_defines.vh"
module qbt_top #(
  parameter WIDTH = `QBT_WIDTH,
  parameter DEPTH = `QBT_DEPTH
) (
  input wire I_MCLK,
  input wire I_RESET,
  input wire I_CE,
  input wire [WIDTH-1:0] I_A,
  input wire [WIDTH-1:0] I_B,
  input wire I_DRIVER_REG_CLOCK,
  input wire [WIDTH-1:0] I_BUS_PULL_OTHERS,
  output reg [WIDTH-1:0] O_BUS_PULL,
  output reg [WIDTH-1:0] O_BUS_OE,
  output wire [WIDTH-1:0] O_RX,
  output wire [WIDTH-1:0] O_RX_OE,
  output reg O_RXQ_VALID,
  output reg [WIDTH-1:0] O_RXQ_DATA,
  input wire I_RXQ_READY,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  output reg [31:0] O_WB_DAT,
  output reg O_WB_ACK
);
  reg [7:0] ctrl_ff; // select, drive enable, hold, output enable
  reg [WIDTH-1:0] drv_ff; // driver register
  reg [WIDTH-1:0] nxt_drv; // next driver register
  reg clk_d_ff; // previous driver clock level
  reg [WIDTH-1:0] bus_ff; // resolved bus sample
  reg [WIDTH-1:0] prev_lat_ff; // latch value last accepted, kept while a word is held back
  reg lat_seen_ff; // held-back latch word not yet queued
  wire sel; // multiplexer select
  wire drv_en_n; // bus drive enable, active low
  wire rx_hold; // receiver latch hold
  wire rx_oe_n; // receiver output enable, active low
  wire [WIDTH-1:0] bus_level; // wired line level
  wire [WIDTH-1:0] lat; // latch contents
  wire [WIDTH-1:0] rx_q; // receiver output register
  wire [WIDTH-1:0] rx_qe; // receiver enable register
  wire q_in_ready; // buffer has room
  wire q_out_valid; // buffer has a word
  wire [WIDTH-1:0] q_out_data; // buffer head
  wire q_push; // new latched word available
  wire q_drain; // output stage or software takes word
  wire sw_pop; // software takes word
  wire wb_req; // new bus request
  assign sel = ctrl_ff[`QBT_CTRL_SEL];
  assign drv_en_n = ctrl_ff[`QBT_CTRL_DRV_N];
  assign rx_hold = ctrl_ff[`QBT_CTRL_HOLD];
  assign rx_oe_n = ctrl_ff[`QBT_CTRL_OE_N];
  assign O_RX = rx_q;
  assign O_RX_OE = rx_qe;
  assign wb_req = I_WB_CYC & I_WB_STB & ~O_WB_ACK;

  // pull-low request of one open-drain line; a set bit pulls, so the line inverts
  function pull_of;
    input bit_val;
    input en_n;
    begin
      pull_of = ~en_n & bit_val;
    end
  endfunction

  // wired level: low when any agent pulls, else pulled up
  assign bus_level = ~(O_BUS_PULL | I_BUS_PULL_OTHERS);

  // multiplexer ahead of each driver flip-flop
  always @* begin
    nxt_drv = drv_ff;
    if (I_DRIVER_REG_CLOCK & ~clk_d_ff) begin
      nxt_drv = sel ? I_B : I_A;
    end
  end

  // driver register and open-drain drive
  always @(posedge I_MCLK) begin : drv_proc
    integer k;
    if (I_RESET) begin
      drv_ff <= {WIDTH{1'b0}};
      clk_d_ff <= 1'b0;
      O_BUS_PULL <= {WIDTH{1'b0}};
      O_BUS_OE <= {WIDTH{1'b0}};
      bus_ff <= {WIDTH{1'b1}};
    end else if (I_CE) begin
      clk_d_ff <= I_DRIVER_REG_CLOCK;
      drv_ff <= nxt_drv;
      bus_ff <= bus_level;
      for (k = 0; k < WIDTH; k = k + 1) begin
        O_BUS_PULL[k] <= pull_of(nxt_drv[k], drv_en_n);
        O_BUS_OE[k] <= pull_of(nxt_drv[k], drv_en_n);
      end
    end
  end

  // receiver path on the resolved bus; double inversion keeps polarity
  qbt_rx_latch #(
    .WIDTH(WIDTH)
  ) u_rx (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_ce(I_CE),
    .i_bus_level(bus_ff),
    .i_hold(rx_hold),
    .i_oe_n(rx_oe_n),
    .o_rx(rx_q),
    .o_rx_oe(rx_qe),
    .o_latch(lat)
  );

  // queue each changed latch word, except one replaced by a newer word while the buffer is full
  assign q_push = lat_seen_ff | (lat != prev_lat_ff);
  assign sw_pop = wb_req & ~I_WB_WE & (I_WB_ADR == `QBT_ADR_RXQ) & q_out_valid;
  assign q_drain = (~O_RXQ_VALID | I_RXQ_READY) | sw_pop;

  // change detector; a word held back by a full buffer retries
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      prev_lat_ff <= {WIDTH{1'b0}};
      lat_seen_ff <= 1'b0;
    end else if (I_CE) begin
      if (q_push & ~q_in_ready) begin
        lat_seen_ff <= 1'b1;
      end else begin
        lat_seen_ff <= 1'b0;
        prev_lat_ff <= lat;
      end
    end
  end

  qbt_fifo2 #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_q (
    .i_clk(I_MCLK),
    .i_rst(I_RESET),
    .i_ce(I_CE),
    .i_valid(q_push),
    .o_ready(q_in_ready),
    .i_data(lat),
    .o_valid(q_out_valid),
    .i_ready(q_drain & ~(O_RXQ_VALID & ~I_RXQ_READY & ~sw_pop)),
    .o_data(q_out_data)
  );

  // output stage of the stream, registered
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      O_RXQ_VALID <= 1'b0;
      O_RXQ_DATA <= {WIDTH{1'b0}};
    end else if (I_CE) begin
      if (~O_RXQ_VALID | I_RXQ_READY) begin
        O_RXQ_VALID <= q_out_valid & ~sw_pop;
        O_RXQ_DATA <= q_out_data;
      end
    end
  end

  // wishbone slave: one-cycle ack, writes honour byte lane 0
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      ctrl_ff <= `QBT_CTRL_RST;
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h00000000;
    end else if (I_CE) begin
      O_WB_ACK <= wb_req;
      if (wb_req) begin
        O_WB_DAT <= 32'h00000000;
        if (I_WB_WE) begin
          if (I_WB_ADR == `QBT_ADR_CTRL && I_WB_SEL[0]) begin
            ctrl_ff <= I_WB_DAT[7:0];
          end
        end else begin
          case (I_WB_ADR)
            `QBT_ADR_CTRL: O_WB_DAT <= {24'h000000, ctrl_ff};
            `QBT_ADR_DATA: O_WB_DAT <= {24'h000000, drv_ff, lat};
            `QBT_ADR_STAT: O_WB_DAT <= {24'h000000, bus_ff, 2'h0, q_in_ready, q_out_valid};
            `QBT_ADR_RXQ: O_WB_DAT <= {23'h000000, q_out_valid, 4'h0, q_out_data};
            default: O_WB_DAT <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule

// ===== hw/qbt_defines.vh
// constants for the quad bus transceiver
`ifndef QBT_DEFINES_VH
`define QBT_DEFINES_VH
`define QBT_WIDTH 4
`define QBT_DEPTH 2
`define QBT_ADR_CTRL 32'h00000000
`define QBT_ADR_DATA 32'h00000004
`define QBT_ADR_STAT 32'h00000008
`define QBT_ADR_RXQ 32'h0000000C
`define QBT_CTRL_SEL 0
`define QBT_CTRL_DRV_N 1
`define QBT_CTRL_HOLD 2
`define QBT_CTRL_OE_N 3
`define QBT_CTRL_RST 8'h0A
`endif

// ===== hw/qbt_fifo2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module qbt_fifo2 #(
  parameter WIDTH = 4,
  parameter DEPTH = 2
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_valid,
  output wire o_ready,
  input wire [WIDTH-1:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // storage words
  reg [1:0] cnt_ff; // entries held
  reg rd_ff; // read pointer
  reg wr_ff; // write pointer
  wire push; // word accepted
  wire pop; // word delivered
  assign o_ready = (cnt_ff != 2'h2);
  assign o_valid = (cnt_ff != 2'h0);
  assign o_data = mem_ff[rd_ff];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  // pointer and count update
  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        mem_ff[wr_ff] <= i_data;
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule

// ===== hw/qbt_rx_latch.v
// receiver: inverting input, latch with hold, shared output enable
`timescale 1ns/1ps
module qbt_rx_latch #(
  parameter WIDTH = 4
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  input wire [WIDTH-1:0] i_bus_level,
  input wire i_hold,
  input wire i_oe_n,
  output reg [WIDTH-1:0] o_rx,
  output reg [WIDTH-1:0] o_rx_oe,
  output wire [WIDTH-1:0] o_latch
);
  reg [WIDTH-1:0] lat_ff; // latch contents
  reg [WIDTH-1:0] nxt_lat; // next latch contents
  assign o_latch = lat_ff;
  // open latch follows the inverted bus, closed latch keeps
  always @* begin
    nxt_lat = lat_ff;
    if (!i_hold) begin
      nxt_lat = ~i_bus_level;
    end
  end
  // latch state, three-state outputs
  always @(posedge i_clk) begin
    if (i_rst) begin
      lat_ff <= {WIDTH{1'b0}};
      o_rx <= {WIDTH{1'b0}};
      o_rx_oe <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      lat_ff <= nxt_lat;
      o_rx <= nxt_lat;
      o_rx_oe <= {WIDTH{~i_oe_n}};
    end
  end
endmodule

// ===== tb/qbt_top_sva.sv
// assertions on the transceiver ports
`timescale 1ns/1ps
module qbt_top_sva (
  input wire I_MCLK,
  input wire I_RESET,
  input wire I_CE,
  input wire [3:0] I_A,
  input wire [3:0] I_B,
  input wire I_DRIVER_REG_CLOCK,
  input wire [3:0] I_BUS_PULL_OTHERS,
  input wire [3:0] O_BUS_PULL,
  input wire [3:0] O_BUS_OE,
  input wire [3:0] O_RX,
  input wire [3:0] O_RX_OE,
  input wire O_RXQ_VALID,
  input wire [3:0] O_RXQ_DATA,
  input wire I_RXQ_READY,
  input wire I_WB_CYC,
  input wire I_WB_STB,
  input wire I_WB_WE,
  input wire [31:0] I_WB_ADR,
  input wire [3:0] I_WB_SEL,
  input wire [31:0] I_WB_DAT,
  input wire O_WB_ACK
);
  reg [3:0] ctl_ff; // shadow control bits
  wire [3:0] mux_w = ctl_ff[0] ? I_B : I_A; // word to load
  wire [3:0] rx_w = O_BUS_PULL | I_BUS_PULL_OTHERS; // inverted line
  // follow control writes taken on the bus
  always @(posedge I_MCLK) begin
    if (I_RESET) begin
      ctl_ff <= 4'hA;
    end else if (I_CE & I_WB_CYC & I_WB_STB & I_WB_WE & ~O_WB_ACK & I_WB_SEL[0] &
                 (I_WB_ADR == 32'h0)) begin
      ctl_ff <= I_WB_DAT[3:0];
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  a_drain_enable: assert property (O_BUS_OE == O_BUS_PULL)
    else $error("enable differs");
  a_load_word: assert property (
    I_CE && I_DRIVER_REG_CLOCK && !$past(I_DRIVER_REG_CLOCK) && !ctl_ff[1]
    |=> O_BUS_PULL == $past(mux_w)) else $error("word not loaded");
  a_drive_off: assert property (ctl_ff[1] && $past(ctl_ff[1]) |-> O_BUS_PULL == 4'h0)
    else $error("pull while off");
  a_rx_enable: assert property (
    ctl_ff[3] == $past(ctl_ff[3]) |-> O_RX_OE == {4{!ctl_ff[3]}}) else $error("rx enable");
  a_rx_follow: assert property (
    !ctl_ff[2] && !$past(ctl_ff[2]) && O_RX_OE[0] && $past(O_RX_OE[0])
    |-> O_RX == $past(rx_w, 2)) else $error("rx not following");
  a_rx_keep: assert property (
    $past(ctl_ff[2]) && O_RX_OE[0] && $past(O_RX_OE[0]) |-> $stable(O_RX))
    else $error("held rx moved");
  a_ack_once: assert property (I_CE && I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK ##1 !O_WB_ACK) else $error("ack timing");
  a_stall_keep: assert property (O_RXQ_VALID && !I_RXQ_READY
    |=> O_RXQ_VALID && $stable(O_RXQ_DATA)) else $error("stalled word lost");
  c_load: cover property (I_DRIVER_REG_CLOCK && !$past(I_DRIVER_REG_CLOCK));
  c_keep: cover property ($past(ctl_ff[2]) && O_RX_OE[0]);
  c_stall: cover property (O_RXQ_VALID && !I_RXQ_READY);
endmodule

// ===== tb/qbt_bus_agent.sv
// other agents on the shared bus
`timescale 1ns/1ps
module qbt_bus_agent (
  input wire i_clk,
  input wire [3:0] i_want,
  output reg [3:0] o_pull = 4'h0
);
  // only pulls low or releases
  always @(posedge i_clk) begin
    o_pull <= i_want;
  end
endmodule

// ===== tb/qbt_top_tb_top.sv
// self-checking bench for the transceiver
`timescale 1ns/1ps
module qbt_top_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg drc = 1'b0; // driver register clock
  reg cyc = 1'b0; // cycle and strobe
  reg we = 1'b0;
  reg rdy = 1'b1; // stream consumer ready
  reg ce = 1'b1; // clock enable
  reg [3:0] a = 4'h0, b = 4'h0, want = 4'h0, h;
  wire [3:0] oe, qd; // drive enable, stream word
  wire qv; // stream valid
  reg [31:0] adr = 32'h0, wd = 32'h0, rd;
  reg [16:0] lf = 17'h10121; // random state
  wire [3:0] oth, pull, rx, rx_oe;
  wire [31:0] rdat;
  wire ack;
  integer comparisons = 0, miscompares = 0, cycles = 0, i;
  qbt_bus_agent qbt_bus_agent_inst (.i_clk(clk), .i_want(want), .o_pull(oth));
  qbt_top qbt_top_inst (.I_MCLK(clk), .I_RESET(rst), .I_CE(ce), .I_A(a), .I_B(b),
    .I_DRIVER_REG_CLOCK(drc), .I_BUS_PULL_OTHERS(oth), .O_BUS_PULL(pull), .O_BUS_OE(oe),
    .O_RX(rx), .O_RX_OE(rx_oe), .O_RXQ_VALID(qv), .O_RXQ_DATA(qd), .I_RXQ_READY(rdy),
    .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
    .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack));
  initial forever #5 clk = ~clk;
  function [16:0] lfsr_nxt(input [16:0] x);
    lfsr_nxt = {x[15:0], x[16] ^ x[13]};
  endfunction
  // receiver word: loaded word or others
  function [3:0] exp_rx(input s, input [3:0] va, input [3:0] vb, input [3:0] vo);
    exp_rx = (s ? vb : va) | vo;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic bus cycle, held until ack
  task wb(input w, input [31:0] ad, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= ad;
    wd <= d;
    // look at ack mid-cycle, where it is settled, then pass the edge that takes it
    @(negedge clk);
    while (ack !== 1'b1) @(negedge clk);
    rd = rdat;
    @(posedge clk);
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  // load words with one driver clock rise
  task load(input [3:0] va, input [3:0] vb, input [3:0] vo, input r);
    @(posedge clk);
    a <= va;
    b <= vb;
    want <= vo;
    rdy <= r;
    drc <= 1'b1;
    @(posedge clk);
    drc <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0A, "ctrl");
    wb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0, "unmapped");
    for (i = 0; i < 16; i = i + 1) begin
      lf = lfsr_nxt(lf);
      wb(1'b1, 32'h0, {31'h0, lf[8]});
      load(lf[3:0], lf[7:4], (i < 8) ? 4'h0 : lf[12:9], lf[13]);
      chk({28'h0, pull}, {28'h0, lf[8] ? lf[7:4] : lf[3:0]}, "pull");
      h = exp_rx(lf[8], lf[3:0], lf[7:4], want);
      chk({28'h0, rx}, {28'h0, h}, "rx");
      chk({28'h0, oe}, {28'h0, pull}, "oe");
    end
    // clock enable low: a driver clock rise must not load
    @(posedge clk);
    ce <= 1'b0;
    load(~a, ~b, want, 1'b1);
    chk({28'h0, pull}, {28'h0, lf[8] ? lf[7:4] : lf[3:0]}, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    wb(1'b1, 32'h0, 32'h4);
    load(~a, ~b, ~want, 1'b1);
    chk({28'h0, rx}, {28'h0, h}, "held");
    wb(1'b1, 32'h0, 32'hC);
    repeat (2) @(posedge clk);
    #1;
    chk({28'h0, rx_oe}, 32'h0, "rx off");
    wb(1'b1, 32'h0, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    chk({28'h0, rx}, {28'h0, h}, "rx kept");
    wb(1'b1, 32'h0, 32'h2);
    load(4'hF, 4'hF, 4'h5, 1'b1);
    chk({28'h0, pull}, 32'h0, "released");
    chk({28'h0, rx}, 32'h5, "others");
    chk({31'h0, qv}, 32'h1, "stream valid");
    chk({28'h0, qd}, 32'h5, "stream word");
    report_and_stop;
  end
endmodule
bind qbt_top qbt_top_sva qbt_top_sva_inst (.*);
